// ===== logic/cfg_loader.v
// Purpose: Loads and updates double-buffered configuration latches.
// Assumes: Host byte strobes arrive synchronous to ref_clk, one at a time.
// Notes: Host bytes are taken after bus framing; ack and nack are pulses.
`timescale 1ns/10ps
`include "cfg_loader_defs.vh"

module cfg_loader #(
    parameter [31:0] ERASE_CYCLES = `ERASE_CYCLES
) (
    input wire ref_clk,
    input wire resetn,
    input wire supply_above_undervoltage_lockout,
    input wire host_byte_valid,
    input wire host_byte_first,
    input wire [7:0] host_byte,
    input wire host_rd_req,
    input wire [7:0] cfg_addr,
    output reg host_ack_ff,
    output reg host_nack_ff,
    output reg host_rd_valid_ff,
    output reg [7:0] host_rd_data_ff,
    output reg [7:0] cfg_data_ff,
    output reg load_done_ff,
    output reg busy_ff
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [4:0] ST_WAIT = 5'h01;
    localparam [4:0] ST_LOAD = 5'h02;
    localparam [4:0] ST_XFER = 5'h04;
    localparam [4:0] ST_READY = 5'h08;
    localparam [4:0] ST_ERASE = 5'h10;

    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [7:0] ctrl_ff;
    reg [15:0] ptr_ff;
    reg lo_pend_ff;
    reg [7:0] idx_ff;
    reg [31:0] erase_cnt_ff;
    reg [3:0] erase_page_ff;
    reg rd_pend_ff;
    reg live_pend_ff;
    reg [7:0] live_idx_ff;
    reg [7:0] stage_a_ff [0:`CFG_BYTES-1];
    reg [7:0] stage_b_ff [0:`CFG_BYTES-1];
    reg [8:0] mem_addr;
    reg mem_we;
    reg [7:0] mem_wdata;
    wire [7:0] mem_rdata;
    wire ready;
    wire take_byte;
    wire data_byte;
    integer i;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function is_nv;
        input [15:0] addr;
        begin
            is_nv = (addr[15:8] == `NV_HI_LOW) || (addr[15:8] == `NV_HI_HIGH);
        end
    endfunction

    function is_cfg;
        input [15:0] addr;
        begin
            is_cfg = (addr[15:8] == 8'h00) && (addr[7:0] <= `CFG_LAST) &&
                     (addr[7:0] != `CTRL_ADDR);
        end
    endfunction

    // A pending commit or reload already counts as busy, so no byte slips in.
    assign ready = state_ff[3] & ~ctrl_ff[`BIT_COMMIT] & ~ctrl_ff[`BIT_RELOAD];
    assign take_byte = host_byte_valid & ready;
    assign data_byte = take_byte & ~host_byte_first & ~lo_pend_ff;

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_WAIT: begin
                if (supply_above_undervoltage_lockout) begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (idx_ff == `CFG_BYTES) begin
                    nxt_state = ST_XFER;
                end
            end
            ST_XFER: begin
                nxt_state = ST_READY;
            end
            ST_READY: begin
                if (ctrl_ff[`BIT_RELOAD]) begin
                    nxt_state = ST_LOAD;
                end else if (ctrl_ff[`BIT_COMMIT]) begin
                    nxt_state = ST_XFER;
                end else if (take_byte && host_byte_first && host_byte == `ERASE_CMD &&
                             ctrl_ff[`BIT_ERASE_EN]) begin
                    nxt_state = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (erase_cnt_ff >= ERASE_CYCLES - 32'h1) begin
                    nxt_state = ST_READY;
                end
            end
            default: begin
                nxt_state = ST_WAIT;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Nonvolatile port
    // ------------------------------------------------------------------
    always @* begin
        mem_addr = ptr_ff[8:0];
        mem_we = 1'b0;
        mem_wdata = host_byte;
        if (state_ff[1]) begin
            mem_addr = {1'b0, idx_ff};
        end else if (state_ff[4]) begin
            mem_addr = {erase_page_ff, idx_ff[4:0]};
            mem_we = (idx_ff < `PAGE_BYTES);
            mem_wdata = 8'h00;
        end else if (data_byte && is_nv(ptr_ff)) begin
            mem_we = 1'b1;
        end
    end

    nv_store u_nv_store (
        .ref_clk(ref_clk),
        .mem_addr(mem_addr),
        .mem_we(mem_we),
        .mem_wdata(mem_wdata),
        .mem_rdata_ff(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Registers and latches
    // ------------------------------------------------------------------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_WAIT;
            ctrl_ff <= `CTRL_RESET;
            ptr_ff <= 16'h0000;
            lo_pend_ff <= 1'b0;
            idx_ff <= 8'h00;
            erase_cnt_ff <= 32'h0;
            erase_page_ff <= 4'h0;
            rd_pend_ff <= 1'b0;
            live_pend_ff <= 1'b0;
            live_idx_ff <= 8'h00;
            host_ack_ff <= 1'b0;
            host_nack_ff <= 1'b0;
            host_rd_valid_ff <= 1'b0;
            host_rd_data_ff <= 8'h00;
            cfg_data_ff <= 8'h00;
            load_done_ff <= 1'b0;
            busy_ff <= 1'b1;
            for (i = 0; i < `CFG_BYTES; i = i + 1) begin
                stage_a_ff[i] <= 8'h00;
                stage_b_ff[i] <= 8'h00;
            end
        end else begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != ST_READY);
            host_ack_ff <= take_byte;
            host_nack_ff <= (host_byte_valid | host_rd_req) & ~ready;
            rd_pend_ff <= host_rd_req & ready;
            host_rd_valid_ff <= rd_pend_ff;
            live_pend_ff <= 1'b0;
            // The second stage follows one cycle after the first.
            if (live_pend_ff) begin
                stage_b_ff[live_idx_ff] <= stage_a_ff[live_idx_ff];
            end
            if (cfg_addr <= `CFG_LAST) begin
                cfg_data_ff <= stage_b_ff[cfg_addr];
            end else begin
                cfg_data_ff <= 8'h00;
            end
            case (state_ff)
                ST_LOAD: begin
                    idx_ff <= idx_ff + 8'h01;
                    if (idx_ff != 8'h00) begin
                        stage_a_ff[idx_ff - 8'h01] <= mem_rdata;
                    end
                end
                ST_XFER: begin
                    for (i = 0; i < `CFG_BYTES; i = i + 1) begin
                        stage_b_ff[i] <= stage_a_ff[i];
                    end
                    ctrl_ff[`BIT_COMMIT] <= 1'b0;
                    ctrl_ff[`BIT_RELOAD] <= 1'b0;
                    load_done_ff <= 1'b1;
                end
                ST_ERASE: begin
                    erase_cnt_ff <= erase_cnt_ff + 32'h1;
                    if (idx_ff < `PAGE_BYTES) begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                default: begin
                    idx_ff <= 8'h00;
                    erase_cnt_ff <= 32'h0;
                end
            endcase
            if (take_byte && host_byte_first) begin
                if (host_byte == `ERASE_CMD) begin
                    erase_page_ff <= ptr_ff[8:5];
                end else if (host_byte == `NV_HI_LOW || host_byte == `NV_HI_HIGH) begin
                    ptr_ff[15:8] <= host_byte;
                    lo_pend_ff <= 1'b1;
                end else begin
                    ptr_ff <= {8'h00, host_byte};
                    lo_pend_ff <= 1'b0;
                end
            end else if (take_byte && lo_pend_ff) begin
                ptr_ff[7:0] <= host_byte;
                lo_pend_ff <= 1'b0;
            end else if (data_byte) begin
                ptr_ff <= ptr_ff + 16'h0001;
                if (ptr_ff == {8'h00, `CTRL_ADDR}) begin
                    ctrl_ff <= host_byte & `CTRL_WR_MASK;
                end else if (is_cfg(ptr_ff)) begin
                    stage_a_ff[ptr_ff[7:0]] <= host_byte;
                    live_pend_ff <= ctrl_ff[`BIT_LIVE];
                    live_idx_ff <= ptr_ff[7:0];
                end
            end else if (rd_pend_ff) begin
                ptr_ff <= ptr_ff + 16'h0001;
                if (is_nv(ptr_ff)) begin
                    host_rd_data_ff <= mem_rdata;
                end else if (ptr_ff == {8'h00, `CTRL_ADDR}) begin
                    host_rd_data_ff <= ctrl_ff & `CTRL_WR_MASK;
                end else if (is_cfg(ptr_ff)) begin
                    host_rd_data_ff <= stage_a_ff[ptr_ff[7:0]];
                end else begin
                    host_rd_data_ff <= 8'h00;
                end
            end
        end
    end

endmodule

// ===== inc/cfg_loader_defs.vh
// Purpose: Constants for the configuration download and update controller.
// Assumes: 250 MHz reference clock.
// Notes: Definitions only.
`ifndef CFG_LOADER_DEFS_VH
`define CFG_LOADER_DEFS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CTRL_ADDR 8'h90
`define CTRL_RESET 8'h00
`define CTRL_WR_MASK 8'h0F
`define BIT_LIVE 0
`define BIT_COMMIT 1
`define BIT_RELOAD 2
`define BIT_ERASE_EN 3
`define ERASE_CMD 8'hFE
`define NV_HI_LOW 8'hF8
`define NV_HI_HIGH 8'hF9

// ----------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------
`define CFG_BYTES 224
`define CFG_LAST 8'hDF
`define NV_BYTES 512
`define PAGE_BYTES 32
`define PAGE_LAST 5'h1F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 250
`define ERASE_TIME_US 20000
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)

`endif

// ===== logic/nv_store.v
// Purpose: Nonvolatile byte store, one write port, registered read.
// Assumes: Contents survive reset; they are not cleared by it.
// Notes: Read data reflect the address of the previous cycle.
`timescale 1ns/10ps
`include "cfg_loader_defs.vh"

module nv_store (
    input wire ref_clk,
    input wire [8:0] mem_addr,
    input wire mem_we,
    input wire [7:0] mem_wdata,
    output reg [7:0] mem_rdata_ff
);

    reg [7:0] cells [0:`NV_BYTES-1];

    always @(posedge ref_clk) begin
        if (mem_we) begin
            cells[mem_addr] <= mem_wdata;
        end
        mem_rdata_ff <= cells[mem_addr];
    end

endmodule

// ===== bench/cfg_loader_sva.sv
// Purpose: Port checker for cfg_loader.
// Assumes: One clock; resetn async, active low.
// Notes: Bound to cfg_loader from tb.
`timescale 1ns/10ps
module cfg_loader_sva (
    input wire ref_clk,
    input wire resetn,
    input wire supply_above_undervoltage_lockout,
    input wire host_byte_valid,
    input wire host_rd_req,
    input wire host_ack_ff,
    input wire host_nack_ff,
    input wire host_rd_valid_ff,
    input wire load_done_ff,
    input wire busy_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_busy_byte_nack: assert property (host_byte_valid && busy_ff |=> host_nack_ff)
        else $error("busy byte not refused");
    a_busy_read_nack: assert property (
        host_rd_req && busy_ff |=> host_nack_ff ##1 !host_rd_valid_ff)
        else $error("busy read not refused");
    a_ack_cause: assert property (
        host_ack_ff |-> $past(host_byte_valid) && !$past(busy_ff))
        else $error("ack without ready byte");
    a_nack_cause: assert property ($rose(host_nack_ff) |-> $past(host_byte_valid || host_rd_req))
        else $error("nack without request");
    a_read_latency: assert property (
        host_rd_req && !busy_ff |=> (!host_nack_ff ##1 host_rd_valid_ff) or
        (host_nack_ff ##1 !host_rd_valid_ff))
        else $error("read answer late");
    a_answer_excl: assert property (!(host_ack_ff && host_nack_ff))
        else $error("ack and nack together");
    a_load_gate: assert property (!load_done_ff |-> busy_ff)
        else $error("ready before load");
    a_done_sticky: assert property (load_done_ff |=> load_done_ff)
        else $error("load done fell");
    a_undervoltage_lockout_hold: assert property (!supply_above_undervoltage_lockout && !load_done_ff |=> !load_done_ff)
        else $error("load under lockout");
    a_load_length: assert property ($rose(load_done_ff) |-> $past(supply_above_undervoltage_lockout, 200))
        else $error("load too short");
endmodule

// ===== bench/host_model.sv
// Purpose: Host side that sends bytes and reads them back.
// Assumes: Byte port below bus framing.
// Notes: Released data shows the inverse of the last byte.
`timescale 1ns/10ps
module host_model (
    input wire ref_clk,
    input wire host_ack_ff,
    input wire host_nack_ff,
    input wire host_rd_valid_ff,
    input wire [7:0] host_rd_data_ff,
    output logic host_byte_valid,
    output logic host_byte_first,
    output logic [7:0] host_byte,
    output logic host_rd_req
);
    initial begin
        host_byte_valid = 1'b0;
        host_byte_first = 1'b0;
        host_byte = 8'h00;
        host_rd_req = 1'b0;
    end
    task automatic send(input logic first, input logic [7:0] b, output logic ok);
        @(posedge ref_clk);
        #1;
        host_byte_valid = 1'b1;
        host_byte_first = first;
        host_byte = b;
        @(posedge ref_clk);
        #1;
        host_byte_valid = 1'b0;
        host_byte_first = 1'b0;
        host_byte = ~b;
        ok = host_ack_ff & ~host_nack_ff;
    endtask
    task automatic fetch(output logic [7:0] d, output logic ok);
        @(posedge ref_clk);
        #1;
        host_rd_req = 1'b1;
        @(posedge ref_clk);
        #1;
        host_rd_req = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        if (host_nack_ff !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            ok = host_rd_valid_ff;
            d = host_rd_data_ff;
        end
    endtask
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench for cfg_loader.
// Assumes: Erase shortened to 64 cycles.
// Notes: Page 0 is erased first so loaded values are known.
`timescale 1ns/10ps
module tb;
    logic ref_clk, resetn, supply_above_undervoltage_lockout, host_byte_valid, host_byte_first, host_rd_req;
    logic [7:0] host_byte, cfg_addr, host_rd_data_ff, cfg_data_ff, d;
    logic host_ack_ff, host_nack_ff, host_rd_valid_ff, load_done_ff, busy_ff, ok;
    int bad_count = 0;
    int n_compared = 0;
    cfg_loader #(.ERASE_CYCLES(64)) cfg_loader_i (.ref_clk, .resetn, .supply_above_undervoltage_lockout,
        .host_byte_valid, .host_byte_first, .host_byte, .host_rd_req, .cfg_addr, .host_ack_ff,
        .host_nack_ff, .host_rd_valid_ff, .host_rd_data_ff, .cfg_data_ff, .load_done_ff,
        .busy_ff);
    host_model host_model_i (.ref_clk, .host_ack_ff, .host_nack_ff, .host_rd_valid_ff,
        .host_rd_data_ff, .host_byte_valid, .host_byte_first, .host_byte, .host_rd_req);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic first, input logic [7:0] b, input logic exp);
        host_model_i.send(first, b, ok);
        chk({7'h00, ok}, {7'h00, exp});
    endtask
    task automatic rd(input logic [7:0] exp);
        host_model_i.fetch(d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask
    task automatic cf(input logic [7:0] a, input logic [7:0] exp);
        cfg_addr = a;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(cfg_data_ff, exp);
    endtask
    // Busy may rise a cycle late, so a few edges pass before polling.
    task automatic idle;
        int n;
        n = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        while (busy_ff !== 1'b0 && n < 500) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({7'h00, busy_ff}, 8'h00);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #40000;
        bad_count++;
        summarize;
    end
    initial begin
        resetn = 1'b0;
        supply_above_undervoltage_lockout = 1'b0;
        cfg_addr = 8'h00;
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        wr(1'b1, 8'h90, 1'b0);
        repeat (300) @(posedge ref_clk);
        #1;
        chk({7'h00, load_done_ff}, 8'h00);
        supply_above_undervoltage_lockout = 1'b1;
        wr(1'b1, 8'h90, 1'b0);
        idle;
        chk({7'h00, load_done_ff}, 8'h01);
        wr(1'b1, 8'h90, 1'b1);
        rd(8'h00);
        wr(1'b1, 8'h90, 1'b1);
        wr(1'b0, 8'hF8, 1'b1);
        wr(1'b1, 8'h90, 1'b1);
        rd(8'h08);
        wr(1'b1, 8'hF8, 1'b1);
        wr(1'b0, 8'h00, 1'b1);
        wr(1'b1, 8'hFE, 1'b1);
        wr(1'b1, 8'h90, 1'b0);
        idle;
        wr(1'b1, 8'hF8, 1'b1);
        wr(1'b0, 8'h05, 1'b1);
        rd(8'h00);
        wr(1'b1, 8'h90, 1'b1);
        wr(1'b0, 8'h0C, 1'b1);
        wr(1'b1, 8'h90, 1'b0);
        idle;
        cf(8'h05, 8'h00);
        wr(1'b1, 8'hF8, 1'b1);
        wr(1'b0, 8'h05, 1'b1);
        wr(1'b0, 8'hA5, 1'b1);
        cf(8'h05, 8'h00);
        wr(1'b1, 8'h90, 1'b1);
        wr(1'b0, 8'h0C, 1'b1);
        idle;
        cf(8'h05, 8'hA5);
        wr(1'b1, 8'h90, 1'b1);
        rd(8'h08);
        wr(1'b1, 8'h90, 1'b1);
        wr(1'b0, 8'h00, 1'b1);
        wr(1'b1, 8'h05, 1'b1);
        wr(1'b0, 8'h11, 1'b1);
        cf(8'h05, 8'hA5);
        wr(1'b1, 8'h05, 1'b1);
        rd(8'h11);
        wr(1'b1, 8'h90, 1'b1);
        wr(1'b0, 8'h02, 1'b1);
        idle;
        cf(8'h05, 8'h11);
        wr(1'b1, 8'h90, 1'b1);
        rd(8'h00);
        wr(1'b1, 8'h90, 1'b1);
        wr(1'b0, 8'h01, 1'b1);
        wr(1'b1, 8'h05, 1'b1);
        wr(1'b0, 8'h22, 1'b1);
        cf(8'h05, 8'h22);
        wr(1'b1, 8'hF8, 1'b1);
        wr(1'b0, 8'h05, 1'b1);
        wr(1'b1, 8'hFE, 1'b1);
        wr(1'b1, 8'hF8, 1'b1);
        wr(1'b0, 8'h05, 1'b1);
        rd(8'hA5);
        summarize;
    end
endmodule
bind cfg_loader cfg_loader_sva cfg_loader_sva_i (.ref_clk, .resetn, .supply_above_undervoltage_lockout,
    .host_byte_valid, .host_rd_req, .host_ack_ff, .host_nack_ff, .host_rd_valid_ff,
    .load_done_ff, .busy_ff);
